// [rtl/tss_pkg.sv]
// Shared constants and types for the time-slot switch
package tss_pkg;

   // ------------------------------------------------------------
   // Stream geometry
   // ------------------------------------------------------------
   localparam int STREAMS  = 8;
   localparam int CHANNELS = 32;
   localparam int BITS     = 8;
   localparam int SLOTS    = STREAMS * CHANNELS;
   localparam int MEM_AW   = 8;
   localparam int ADDR_W   = 6;
   localparam int DATA_W   = 8;
   localparam int CNT_W    = 9;

   // ------------------------------------------------------------
   // Frame counter fields (counts falling edges of the 2x clock)
   // ------------------------------------------------------------
   localparam int CNT_PHASE_BIT = 0;
   localparam int CNT_BIT_LO    = 1;
   localparam int CNT_BIT_HI    = 3;
   localparam int CNT_CHAN_LO   = 4;
   localparam int CNT_CHAN_HI   = 8;
   localparam int CNT_SLOT_LO   = 1;
   localparam logic [CNT_W-1:0] CNT_RESET = 9'h000;
   localparam logic [CNT_W-1:0] CNT_STEP  = 9'h001;
   localparam logic [2:0]       LAST_BIT  = 3'h7;
   localparam logic [2:0]       FIRST_BIT = 3'h0;

   // ------------------------------------------------------------
   // Host address and control register fields
   // ------------------------------------------------------------
   localparam int ADDR_SPACE_BIT = 5;
   localparam int CTRL_SPLIT_BIT = 7;
   localparam int CTRL_BCAST_BIT = 6;
   localparam int CTRL_MSEL_HI   = 4;
   localparam int CTRL_MSEL_LO   = 3;
   localparam int CTRL_STREAM_HI = 2;
   localparam logic [1:0] MSEL_CONN_LOW  = 2'h2;
   localparam logic [1:0] MSEL_CONN_HIGH = 2'h3;
   localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

   // ------------------------------------------------------------
   // Connection memory high fields
   // ------------------------------------------------------------
   localparam int CMH_W       = 3;
   localparam int CMH_MSG_BIT = 0;
   localparam int CMH_CST_BIT = 1;
   localparam int CMH_OE_BIT  = 2;
   localparam logic [CMH_W-1:0] CMH_RESET = 3'h0;
   localparam logic [CMH_W-1:0] CMH_FORCE = 3'h5;

   typedef enum logic {H_IDLE, H_ACK} host_state_t;

endpackage : tss_pkg

// [rtl/tss_lane.sv]
// One serial lane: receive shifter and transmit shifter
`timescale 1ns/100ps
`default_nettype none

module tss_lane
  #(parameter int BITS = tss_pkg::BITS)
  (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            serial_in,
   input  wire logic            sample,
   input  wire logic            load,
   input  wire logic            shift,
   input  wire logic [BITS-1:0] load_byte,
   input  wire logic            load_en,
   output logic                 serial_out,
   output logic                 out_en,
   output logic [BITS-1:0]      rx_byte
   );
   import tss_pkg::*;

   typedef struct packed {
      logic [BITS-1:0] rx_sh;
      logic [BITS-1:0] tx_sh;
      logic            en;
   } lane_t;

   lane_t st_q;
   lane_t st_d;

   // Byte as it stands once the current sample is shifted in, msb first
   assign rx_byte    = {st_q.rx_sh[BITS-2:0], serial_in};
   assign serial_out = st_q.tx_sh[BITS-1];
   assign out_en     = st_q.en;

   always_comb
   begin
      st_d = st_q;
      if (sample)
      begin
         st_d.rx_sh = rx_byte;
      end
      if (load)
      begin
         st_d.tx_sh = load_byte;
         st_d.en    = load_en;
      end
      else if (shift)
      begin
         st_d.tx_sh = {st_q.tx_sh[BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Transmit byte moves only on cell boundaries
   tx_shift_only_a: assert property (@(posedge clk) disable iff (rst)
      (!load && !shift) |=> (st_q.tx_sh == $past(st_q.tx_sh)))
      else $error("transmit shifter moved outside a bit boundary");

endmodule : tss_lane

`default_nettype wire

// [rtl/tss_switch.sv]
// Time-slot interchange switch: 8 serial streams in, 8 out, host access port
//
// Operation
// - Eight serial inputs and outputs, 32 channels.
// - Any output channel takes any input channel.
// - Low frame pulse resets counter at falling edge.
// - Bit cell is two 2x clock periods.
// - Acknowledge pulled low after access processed.
// - Data bus driven only during reads.
// - Drive gate low tri-states all eight serial stream outputs.
// - Per-channel tri-state from connection high.
// - Control stream carries connection high bit 1.
// - Address 5 low selects control register.
// - Connection low addresses data memory for switching.
// - Frame is 32 continuous eight-bit channels.
// - Broadcast bit forces message and enable.
`timescale 1ns/100ps
`default_nettype none

module tss_switch
  (
   input  wire logic                         CLOCK,
   input  wire logic                         RESET,
   input  wire logic                         DOUBLE_RATE_CLOCK,
   input  wire logic                         FRAME_PULSE_N,
   input  wire logic [tss_pkg::STREAMS-1:0]  SERIAL_IN_LINES,
   output logic      [tss_pkg::STREAMS-1:0]  SERIAL_OUT_LINES,
   output logic      [tss_pkg::STREAMS-1:0]  SERIAL_OUT_OE_N,
   input  wire logic                         SERIAL_DRIVE_GATE,
   output logic                              CONTROL_STREAM_OUT,
   input  wire logic [tss_pkg::ADDR_W-1:0]   HOST_ADDR,
   input  wire logic [tss_pkg::DATA_W-1:0]   HOST_DATA_IN,
   output logic      [tss_pkg::DATA_W-1:0]   HOST_DATA_OUT,
   output logic                              HOST_DATA_OE_N,
   input  wire logic                         HOST_STROBE,
   input  wire logic                         READ_WRITE,
   input  wire logic                         CHIP_SELECT_N,
   input  wire logic                         TRANSFER_ACK_N_IN,
   output logic                              TRANSFER_ACK_N_OUT,
   output logic                              TRANSFER_ACK_OE_N
   );
   import tss_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic              c4_prev;
      logic [CNT_W-1:0]  cnt;
      logic [DATA_W-1:0] ctrl;
      host_state_t       hst;
      logic              rd_cycle;
      logic [DATA_W-1:0] rd_data;
      logic              cst;
   } sw_state_t;

   sw_state_t st_q;
   sw_state_t st_d;

   // Memories are arrays; only connection high is reset so no slot
   // drives garbage before software has set it up
   logic [DATA_W-1:0] data_mem_q  [SLOTS];
   logic [DATA_W-1:0] conn_low_q  [SLOTS];
   logic [CMH_W-1:0]  conn_high_q [SLOTS];

   // ------------------------------------------------------------
   // Frame timing
   // ------------------------------------------------------------
   logic             c4_fall;
   logic [CNT_W-1:0] cnt_nx;
   logic             boundary;
   logic             load_now;
   logic             shift_now;
   logic             sample_now;
   logic             last_sample;
   logic [4:0]       chan_nx;
   logic [MEM_AW-1:0] slot_nx;

   // The 2x clock is a sampled pin; a fall is seen one CLOCK late,
   // which is harmless since every lane uses the same event
   assign c4_fall = st_q.c4_prev & ~DOUBLE_RATE_CLOCK;

   assign cnt_nx = (!FRAME_PULSE_N) ? CNT_RESET : st_q.cnt + CNT_STEP;

   assign boundary    = c4_fall & ~cnt_nx[CNT_PHASE_BIT];
   assign sample_now  = c4_fall & cnt_nx[CNT_PHASE_BIT];
   assign load_now    = boundary & (cnt_nx[CNT_BIT_HI:CNT_BIT_LO] == FIRST_BIT);
   assign shift_now   = boundary & ~load_now;
   assign last_sample = sample_now & (cnt_nx[CNT_BIT_HI:CNT_BIT_LO] == LAST_BIT);
   assign chan_nx     = cnt_nx[CNT_CHAN_HI:CNT_CHAN_LO];
   assign slot_nx     = cnt_nx[CNT_CHAN_HI:CNT_SLOT_LO];

   // ------------------------------------------------------------
   // Serial lanes
   // ------------------------------------------------------------
   logic [STREAMS-1:0] lane_en;
   logic [STREAMS-1:0] lane_out;
   logic [DATA_W-1:0]  rx_byte  [STREAMS];

   for (genvar s = 0; s < STREAMS; s++)
   begin : g_lane
      logic [MEM_AW-1:0] slot;
      logic [CMH_W-1:0]  high;
      logic [DATA_W-1:0] tx_byte;

      assign slot = {3'(s), chan_nx};

      assign high = conn_high_q[slot] | (st_q.ctrl[CTRL_BCAST_BIT] ? CMH_FORCE : CMH_RESET);

      assign tx_byte = high[CMH_MSG_BIT] ? conn_low_q[slot] : data_mem_q[conn_low_q[slot]];

      tss_lane #(.BITS(DATA_W)) u_lane
        (
         .clk        (CLOCK),
         .rst        (RESET),
         .serial_in  (SERIAL_IN_LINES[s]),
         .sample     (sample_now),
         .load       (load_now),
         .shift      (shift_now),
         .load_byte  (tx_byte),
         .load_en    (high[CMH_OE_BIT]),
         .serial_out (lane_out[s]),
         .out_en     (lane_en[s]),
         .rx_byte    (rx_byte[s])
         );
   end

   assign SERIAL_OUT_LINES   = lane_out;
   assign SERIAL_OUT_OE_N    = ~(lane_en & {STREAMS{SERIAL_DRIVE_GATE}});
   assign CONTROL_STREAM_OUT = st_q.cst;

   // ------------------------------------------------------------
   // Host access decode
   // ------------------------------------------------------------
   logic              access;
   logic              is_ctrl;
   logic [1:0]        msel;
   logic              split;
   logic [MEM_AW-1:0] host_slot;
   logic              wr_conn_low;
   logic              wr_conn_high;
   logic [DATA_W-1:0] rd_mux;

   assign access    = HOST_STROBE & ~CHIP_SELECT_N;
   assign is_ctrl   = ~HOST_ADDR[ADDR_SPACE_BIT];
   assign msel      = st_q.ctrl[CTRL_MSEL_HI:CTRL_MSEL_LO];
   assign split     = st_q.ctrl[CTRL_SPLIT_BIT];
   assign host_slot = {st_q.ctrl[CTRL_STREAM_HI:0], HOST_ADDR[4:0]};

   assign wr_conn_low  = (st_q.hst == H_IDLE) & access & ~READ_WRITE & ~is_ctrl
                         & (split | (msel == MSEL_CONN_LOW));
   assign wr_conn_high = (st_q.hst == H_IDLE) & access & ~READ_WRITE & ~is_ctrl
                         & ~split & (msel == MSEL_CONN_HIGH);

   always_comb
   begin
      if (is_ctrl)
      begin
         rd_mux = st_q.ctrl;
      end
      else if (split)
      begin
         rd_mux = data_mem_q[host_slot];
      end
      else if (msel == MSEL_CONN_LOW)
      begin
         rd_mux = conn_low_q[host_slot];
      end
      else if (msel == MSEL_CONN_HIGH)
      begin
         rd_mux = {5'h00, conn_high_q[host_slot]};
      end
      else
      begin
         rd_mux = data_mem_q[host_slot];
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      st_d         = st_q;
      st_d.c4_prev = DOUBLE_RATE_CLOCK;
      if (c4_fall)
      begin
         st_d.cnt = cnt_nx;
      end
      if (boundary)
      begin
         st_d.cst = conn_high_q[slot_nx][CMH_CST_BIT];
      end
      unique case (st_q.hst)
         H_IDLE:
         begin
            if (access)
            begin
               st_d.hst      = H_ACK;
               st_d.rd_cycle = READ_WRITE;
               st_d.rd_data  = rd_mux;
               if (!READ_WRITE && is_ctrl)
               begin
                  st_d.ctrl = HOST_DATA_IN;
               end
            end
         end
         H_ACK:
         begin
            if (!access)
            begin
               st_d.hst      = H_IDLE;
               st_d.rd_cycle = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         st_q      <= '0;
         st_q.cnt  <= CNT_RESET;
         st_q.ctrl <= CTRL_RESET;
         st_q.hst  <= H_IDLE;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // Memories
   // ------------------------------------------------------------
   always_ff @(posedge CLOCK)
   begin
      if (last_sample)
      begin
         for (int s = 0; s < STREAMS; s++)
         begin
            data_mem_q[{3'(s), chan_nx}] <= rx_byte[s];
         end
      end
      if (wr_conn_low)
      begin
         conn_low_q[host_slot] <= HOST_DATA_IN;
      end
      if (RESET)
      begin
         for (int i = 0; i < SLOTS; i++)
         begin
            conn_high_q[i] <= CMH_RESET;
         end
      end
      else if (wr_conn_high)
      begin
         conn_high_q[host_slot] <= HOST_DATA_IN[CMH_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Host pins
   // ------------------------------------------------------------
   // acknowledge while processed
   assign TRANSFER_ACK_N_OUT = 1'b0;
   assign TRANSFER_ACK_OE_N  = ~(st_q.hst == H_ACK);
   assign HOST_DATA_OUT      = st_q.rd_data;
   assign HOST_DATA_OE_N     = ~((st_q.hst == H_ACK) & st_q.rd_cycle);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   ack_follows_access_a: assert property (@(posedge CLOCK) disable iff (RESET)
      ((st_q.hst == H_IDLE) && HOST_STROBE && !CHIP_SELECT_N) |=> !TRANSFER_ACK_OE_N)
      else $error("acknowledge not driven after an access");

   ack_release_a: assert property (@(posedge CLOCK) disable iff (RESET)
      (!TRANSFER_ACK_OE_N && (!HOST_STROBE || CHIP_SELECT_N)) |=> TRANSFER_ACK_OE_N)
      else $error("acknowledge held after strobe or select dropped");

   select_ignore_a: assert property (@(posedge CLOCK) disable iff (RESET)
      (TRANSFER_ACK_OE_N && CHIP_SELECT_N) |=> TRANSFER_ACK_OE_N)
      else $error("access taken while deselected");

   bus_drive_a: assert property (@(posedge CLOCK) disable iff (RESET)
      (!HOST_DATA_OE_N) |-> (!TRANSFER_ACK_OE_N && $past(READ_WRITE) || $past(!HOST_DATA_OE_N)))
      else $error("data bus driven outside a read");

   ctrl_write_a: assert property (@(posedge CLOCK) disable iff (RESET)
      ((st_q.hst == H_IDLE) && access && !READ_WRITE && !HOST_ADDR[ADDR_SPACE_BIT])
      |=> (st_q.ctrl == $past(HOST_DATA_IN)))
      else $error("control register write lost");

   drive_gate_a: assert property (@(posedge CLOCK) disable iff (RESET)
      (!SERIAL_DRIVE_GATE) |-> (SERIAL_OUT_OE_N == 8'hFF))
      else $error("serial output driven with gate low");

   frame_reset_a: assert property (@(posedge CLOCK) disable iff (RESET)
      (c4_fall && !FRAME_PULSE_N) |=> (st_q.cnt == CNT_RESET) ##1 (st_q.cnt == CNT_RESET))
      else $error("frame counter not reset by frame pulse");

   broadcast_en_a: assert property (@(posedge CLOCK) disable iff (RESET)
      (load_now && st_q.ctrl[CTRL_BCAST_BIT]) |=> (lane_en == 8'hFF))
      else $error("broadcast did not enable every lane");

   cell_change_a: assert property (@(posedge CLOCK) disable iff (RESET)
      (!$stable(SERIAL_OUT_LINES)) |-> ($past(c4_fall) && (st_q.cnt[CNT_PHASE_BIT] == 1'b0)))
      else $error("serial output changed inside a bit cell");

   ack_pin_low_a: assert property (@(posedge CLOCK) disable iff (RESET)
      (!TRANSFER_ACK_OE_N) |-> (!TRANSFER_ACK_N_IN))
      else $error("acknowledge pin not low while pulled");

endmodule : tss_switch

`default_nettype wire

// [tb/tss_stream_model.sv]
// Serial stream partner: frame timing, input pattern, output capture
`timescale 1ns/100ps
`default_nettype none

module tss_stream_model
  (
   output logic                           c4,
   output logic                           fp_n,
   output logic      [tss_pkg::STREAMS-1:0] si,
   input  wire logic [tss_pkg::STREAMS-1:0] so,
   input  wire logic [tss_pkg::STREAMS-1:0] so_oe_n,
   input  wire logic                      cst
   );
   import tss_pkg::*;

   logic [BITS-1:0] rx_byte [STREAMS][CHANNELS];
   logic            rx_en   [STREAMS][CHANNELS];
   logic            cst_bit [SLOTS];
   logic [7:0]      pat;
   int              fall   = 510;
   int              frames = 0;
   int              ch;
   int              bi;

   initial
   begin
      c4 = 1'b1;
      fp_n = 1'b1;
      si = '0;
   end

   always #122.1 c4 = ~c4;

   always @(posedge c4) fp_n <= (fall != 511);

   always @(negedge c4)
   begin
      fall = (fall + 1) % 512;
      ch = fall / 16;
      bi = 7 - (fall / 2) % 8;
      for (int s = 0; s < STREAMS; s++)
      begin
         // Inverted address as payload, so switched and message data differ
         pat = 8'(s * CHANNELS + ch);
         if (fall % 2 == 0)
            si[s] <= ~pat[bi];
         else
         begin
            // Released pin shows the inverse, so a stale level is not taken for data
            rx_byte[s][ch][bi] = so[s] ^ so_oe_n[s];
            rx_en[s][ch] = (bi == 7) ? !so_oe_n[s] : rx_en[s][ch] & !so_oe_n[s];
         end
      end
      if (fall % 2 == 1)
         cst_bit[fall / 2] = cst;
      if (fall == 511)
         frames++;
   end

endmodule : tss_stream_model
`default_nettype wire

// [tb/test_tss_switch.sv]
// Self-checking bench for the time-slot switch
`timescale 1ns/100ps
`default_nettype none

module test_tss_switch;
   import tss_pkg::*;

   logic                clock  = 1'b0;
   logic                reset  = 1'b1;
   logic                gate   = 1'b1;
   logic [ADDR_W-1:0]   addr   = '0;
   logic [DATA_W-1:0]   wdata  = '0;
   logic                strobe = 1'b0;
   logic                rw     = 1'b1;
   logic                cs_n   = 1'b1;
   logic [DATA_W-1:0]   rd;
   wire logic           c4, fp_n, cst, d_oe_n, ack_n, ack_oe_n;
   wire logic [7:0]     si, so, so_oe_n;
   wire logic [7:0]     d_out, d_bus;
   int                  n_fail   = 0;
   int                  compares = 0;
   int                  cycles   = 0;

   // Shared wires resolved from the switch's enables; the bench drives the bus otherwise
   assign d_bus = d_oe_n ? wdata : d_out;
   wire logic ack_pin = ack_oe_n ? 1'b1 : ack_n;

   always #20 clock = ~clock;

   tss_switch tss_switch_i (.CLOCK(clock), .RESET(reset), .DOUBLE_RATE_CLOCK(c4), .FRAME_PULSE_N(fp_n),
      .SERIAL_IN_LINES(si), .SERIAL_OUT_LINES(so), .SERIAL_OUT_OE_N(so_oe_n), .SERIAL_DRIVE_GATE(gate),
      .CONTROL_STREAM_OUT(cst), .HOST_ADDR(addr), .HOST_DATA_IN(d_bus), .HOST_DATA_OUT(d_out),
      .HOST_DATA_OE_N(d_oe_n), .HOST_STROBE(strobe), .READ_WRITE(rw), .CHIP_SELECT_N(cs_n),
      .TRANSFER_ACK_N_IN(ack_pin), .TRANSFER_ACK_N_OUT(ack_n), .TRANSFER_ACK_OE_N(ack_oe_n));

   tss_stream_model tss_stream_model_i (.c4(c4), .fp_n(fp_n), .si(si), .so(so), .so_oe_n(so_oe_n), .cst(cst));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t flag %b want %b", $time, got, exp);
      end
   endtask : chk1

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask : done

   // Held until acknowledged; a held strobe is one access only
   task automatic access(input logic r, input logic [5:0] a, input logic [7:0] w);
      int n;
      @(posedge clock);
      rw <= r;
      addr <= a;
      wdata <= w;
      cs_n <= 1'b0;
      strobe <= 1'b1;
      n = 0;
      @(negedge clock);
      while (ack_pin !== 1'b0 && n < 8)
      begin
         @(negedge clock);
         n++;
      end
      chk1(ack_pin, 1'b0);
      chk1(d_oe_n, !r);
      rd = d_bus;
      @(posedge clock);
      strobe <= 1'b0;
      cs_n <= 1'b1;
      repeat (3) @(negedge clock);
      chk1(ack_pin, 1'b1);
      chk1(d_oe_n, 1'b1);
   endtask : access

   task automatic set_entry(input logic [1:0] ms, input logic [2:0] s, input logic [4:0] c, input logic [7:0] v);
      access(1'b0, 6'h00, {3'h0, ms, s});
      access(1'b0, {1'b1, c}, v);
   endtask : set_entry

   task automatic wait_frames(input int n);
      int f;
      f = tss_stream_model_i.frames + n;
      while (tss_stream_model_i.frames < f)
         @(posedge clock);
   endtask : wait_frames

   function automatic logic en_exp(input int s, input int c);
      return (s == 3 && c == 7) || (s == 1 && c == 3) || (s == 7 && c == 31);
   endfunction : en_exp

   task automatic chk_en(input int mode);
      for (int s = 0; s < STREAMS; s++)
         for (int c = 0; c < CHANNELS; c++)
            chk1(tss_stream_model_i.rx_en[s][c], mode == 2 || (mode == 1 && en_exp(s, c)));
   endtask : chk_en

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk8(so_oe_n, 8'hFF);
      chk1(ack_pin, 1'b1);
      chk1(d_oe_n, 1'b1);
      chk1(cst, 1'b0);
      done("reset");
   endtask : t_reset

   task automatic t_ctrl;
      access(1'b0, 6'h1F, 8'h2D);
      access(1'b1, 6'h00, 8'h00);
      chk8(rd, 8'h2D);
      access(1'b1, 6'h15, 8'h00);
      chk8(rd, 8'h2D);
      done("control");
   endtask : t_ctrl

   task automatic t_cs;
      @(posedge clock);
      rw <= 1'b0;
      wdata <= 8'h11;
      strobe <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         @(negedge clock);
         chk1(ack_pin, 1'b1);
      end
      @(posedge clock);
      strobe <= 1'b0;
      access(1'b1, 6'h00, 8'h00);
      chk8(rd, 8'h2D);
      done("deselected");
   endtask : t_cs

   task automatic t_conn;
      set_entry(MSEL_CONN_LOW, 3'h3, 5'h07, 8'hB4);
      set_entry(MSEL_CONN_HIGH, 3'h3, 5'h07, 8'h04);
      set_entry(MSEL_CONN_LOW, 3'h7, 5'h1F, 8'h1F);
      set_entry(MSEL_CONN_HIGH, 3'h7, 5'h1F, 8'h04);
      set_entry(MSEL_CONN_LOW, 3'h1, 5'h03, 8'hC3);
      set_entry(MSEL_CONN_HIGH, 3'h1, 5'h03, 8'hFD);
      set_entry(MSEL_CONN_LOW, 3'h2, 5'h04, 8'h10);
      set_entry(MSEL_CONN_HIGH, 3'h2, 5'h04, 8'h02);
      access(1'b1, 6'h24, 8'h00);
      chk8(rd, 8'h02);
      access(1'b0, 6'h00, {3'h0, MSEL_CONN_HIGH, 3'h1});
      access(1'b1, 6'h23, 8'h00);
      chk8(rd, 8'h05);
      access(1'b0, 6'h00, {3'h0, MSEL_CONN_LOW, 3'h1});
      access(1'b1, 6'h23, 8'h00);
      chk8(rd, 8'hC3);
      done("connections");
   endtask : t_conn

   task automatic t_switch;
      wait_frames(3);
      chk8(tss_stream_model_i.rx_byte[3][7], 8'h4B);
      chk8(tss_stream_model_i.rx_byte[7][31], 8'hE0);
      chk8(tss_stream_model_i.rx_byte[1][3], 8'hC3);
      chk_en(1);
      for (int k = 0; k < SLOTS; k++)
         chk1(tss_stream_model_i.cst_bit[k], k == 68);
      done("switching");
   endtask : t_switch

   task automatic t_gate;
      @(posedge clock);
      gate <= 1'b0;
      @(negedge clock);
      chk8(so_oe_n, 8'hFF);
      wait_frames(2);
      chk_en(0);
      @(posedge clock);
      gate <= 1'b1;
      done("gate");
   endtask : t_gate

   task automatic t_bcast;
      access(1'b0, 6'h00, 8'h40);
      wait_frames(2);
      chk_en(2);
      chk8(tss_stream_model_i.rx_byte[3][7], 8'hB4);
      chk8(tss_stream_model_i.rx_byte[2][4], 8'h10);
      access(1'b0, 6'h00, 8'h00);
      done("broadcast");
   endtask : t_bcast

   // Split mode reads data memory and writes connection low; memory select 0 reads data memory
   task automatic t_split;
      access(1'b0, 6'h00, 8'h85);
      access(1'b1, 6'h34, 8'h00);
      chk8(rd, 8'h4B);
      access(1'b0, 6'h34, 8'h5A);
      access(1'b0, 6'h00, {3'h0, MSEL_CONN_LOW, 3'h5});
      access(1'b1, 6'h34, 8'h00);
      chk8(rd, 8'h5A);
      access(1'b0, 6'h00, 8'h05);
      access(1'b1, 6'h34, 8'h00);
      chk8(rd, 8'h4B);
      done("split");
   endtask : t_split

   task automatic final_report;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   // Seven frames of about 3125 cycles plus host traffic
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         n_fail++;
         $display("BAD t=%0t timeout", $time);
         final_report;
      end
   end

   initial
   begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      @(negedge clock);
      t_reset;
      t_ctrl;
      t_cs;
      t_conn;
      t_switch;
      t_gate;
      t_bcast;
      t_split;
      final_report;
   end

endmodule : test_tss_switch
`default_nettype wire
